/* sim/scdr_host_sink.sv */
// Host memory side model: accepts words that leave the chain buffer.
// Assumes the testbench raises stall to make host memory slow.
`timescale 1ns/100ps
module scdr_host_sink
   import scdr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Words toward host memory
   input wire logic outValid,
   output logic outReady,
   input wire scdr_xfer_t outXfer,
   // Pacing and tally
   input wire logic stall,
   output int wordCount,
   output logic [31:0] lastData
);
   // Ready is registered, so a stall takes hold one cycle late, as real hosts do
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outReady <= 1'b0;
         wordCount <= 0;
         lastData <= 32'h0000_0000;
      end else begin
         outReady <= !stall;
         if (outValid && outReady) begin
            wordCount <= wordCount + 1;
            lastData <= outXfer.data;
         end
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the chain reload block with a host memory model.
// Assumes the designer's one-wait-cycle Avalon slave and registered outputs.
`timescale 1ns/100ps
module testbench
   import scdr_pkg::*;
;
   logic clk, rst_n, read, write, inValid, stall, outValid, outReady, inReady;
   logic waitrequest, descFetch, dmaActive, dmaDirection;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q, lastData;
   logic [63:0] descAddr;
   scdr_xfer_t inXfer, outXfer;
   int bad_count, total_checks, wordCount;
   int fetchCount = 0;
   logic [31:0] v [4] = '{32'h1000_0040, 32'h0000_0002, 32'h0000_0007, 32'h0000_0001};
   scdr_chain_reload uut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .inValid(inValid), .inReady(inReady), .inXfer(inXfer),
      .outValid(outValid), .outReady(outReady), .outXfer(outXfer), .descFetch(descFetch),
      .descAddr(descAddr), .dmaActive(dmaActive), .dmaDirection(dmaDirection));
   scdr_host_sink host (.clk(clk), .rst_n(rst_n), .outValid(outValid), .outReady(outReady),
      .outXfer(outXfer), .stall(stall), .wordCount(wordCount), .lastData(lastData));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end
   // Counting cycles, not edges, so a stretched pulse shows up as extra fetches
   always @(posedge clk) if (descFetch === 1'b1) fetchCount <= fetchCount + 1;
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      // Sampled at the rising edge, before that edge's register updates land
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) bad_count++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(negedge clk);
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e, input string n);
      acc(1'b0, a, 32'h0000_0000);
      chk(n, e, q);
   endtask
   task push(input logic [2:0] b);
      int n;
      n = 0;
      @(posedge clk);
      inValid <= 1'b1;
      inXfer <= {32'hC0DE_0000 | b, b};
      @(posedge clk);
      while (inReady !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) bad_count++;
      inValid <= 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task give_verdict;
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict;
   end
   initial begin
      {rst_n, read, write, inValid, stall, address, writedata, inXfer} = '0;
      {bad_count, total_checks} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0, "reset");
      for (int i = 0; i < 4; i++) acc(1'b1, 5'(i * 4), v[i]);
      for (int i = 0; i < 4; i++) rd(5'(i * 4), v[i], "reg");
      acc(1'b1, OFF_REM_LO, 32'hFFFF_FFFF);
      rd(OFF_REM_LO, 32'h0, "remRO");
      $display("Test registers done");
      acc(1'b1, OFF_CTRL, 32'h0000_0011);
      chk("active", 1, dmaActive);
      chk("dir0", 0, dmaDirection);
      chk("head", 64'h0000_0002_1000_0040, descAddr);
      rd(OFF_REM_HI, 32'h1, "remHi");
      // The fetch pulse is tallied at the edge after it, so look once a read has passed
      chk("fetch", 1, fetchCount);
      rd(OFF_CTRL, 32'h0000_0021, "ctrl");
      acc(1'b1, OFF_PTR_LO, 32'h2000_0080);
      chk("headHeld", 64'h0000_0002_1000_0040, descAddr);
      push(3'h4);
      rd(OFF_REM_LO, 32'h3, "remDec");
      chk("data", 32'hC0DE_0004, lastData);
      acc(1'b1, OFF_CTRL, 32'h0000_0003);
      chk("abort", 0, dmaActive);
      $display("Test start and abort done");
      acc(1'b1, OFF_SIZE_HI, 32'h0);
      acc(1'b1, OFF_CTRL, 32'h0000_0015);
      chk("dir1", 1, dmaDirection);
      chk("head2", 64'h0000_0002_2000_0080, descAddr);
      @(posedge clk);
      stall <= 1'b1;
      push(3'h4);
      push(3'h4);
      chk("full", 0, inReady);
      @(posedge clk);
      stall <= 1'b0;
      repeat (8) @(negedge clk);
      rd(OFF_REM_LO, 32'h7, "reload");
      chk("fetch3", 3, fetchCount);
      chk("words", 3, wordCount);
      acc(1'b1, OFF_CTRL, 32'h0000_0014);
      push(3'h4);
      push(3'h3);
      chk("stop", 0, dmaActive);
      chk("fetch4", 4, fetchCount);
      $display("Test reload done");
      give_verdict;
   end
endmodule

/* src/scdr_chain_reload.sv */
// Chain control of a scatter-gather DMA engine: head pointer, chain byte total,
// remaining-byte counter with reload, and a two-entry buffer on the transfer path.
// Assumes the data mover presents transfers upstream and the host bus drains them.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module scdr_chain_reload
   import scdr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Transfers from the data mover
   input wire logic inValid,
   output logic inReady,
   input wire scdr_xfer_t inXfer,
   // Transfers toward host memory
   output logic outValid,
   input wire logic outReady,
   output scdr_xfer_t outXfer,
   // Descriptor fetch and engine status
   output logic descFetch,
   output logic [63:0] descAddr,
   output logic dmaActive,
   output logic dmaDirection
);

   scdr_state_t st_r;
   scdr_state_t st_nxt;
   logic wrAcc;
   logic rdAcc;
   logic ctrlWr;
   logic inFire;
   logic outFire;
   logic [63:0] moved;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   // One wait cycle per access: the request is seen, then answered at the next edge
   assign waitrequest = (read | write) & ~st_r.ack;
   assign wrAcc = write & st_r.ack;
   assign rdAcc = read & st_r.ack;
   assign ctrlWr = wrAcc & (address == OFF_CTRL) & byteenable[0];
   assign inReady = st_r.active & (st_r.fill < BUF_DEPTH);
   assign inFire = inValid & inReady;
   assign outValid = st_r.fill != 2'h0;
   assign outFire = outValid & outReady;
   assign outXfer = st_r.entry[0];
   // Never count past zero, even if the mover reports more than remains
   assign moved = (64'(st_r.entry[0].bytes) > st_r.rem) ? st_r.rem : 64'(st_r.entry[0].bytes);
   assign readdata = st_r.rdata;
   assign descFetch = st_r.fetch;
   assign descAddr = st_r.descAddr;
   assign dmaActive = st_r.active;
   assign dmaDirection = st_r.dir;

   always_comb begin
      st_nxt = st_r;
      st_nxt.fetch = 1'b0;
      st_nxt.ack = (read | write) & ~st_r.ack;
      // Read data is captured while waiting so it is stable at the answering edge
      if (read & ~st_r.ack) begin
         unique case (address)
            OFF_PTR_LO: st_nxt.rdata = st_r.ptr[31:0];
            OFF_PTR_HI: st_nxt.rdata = st_r.ptr[63:32];
            OFF_SIZE_LO: st_nxt.rdata = st_r.size[31:0];
            OFF_SIZE_HI: st_nxt.rdata = st_r.size[63:32];
            OFF_REM_LO: st_nxt.rdata = st_r.rem[31:0];
            OFF_REM_HI: st_nxt.rdata = st_r.rem[63:32];
            OFF_CTRL: begin
               st_nxt.rdata = RST_WORD;
               st_nxt.rdata[BIT_AUTO] = st_r.autoStart;
               st_nxt.rdata[BIT_DIR] = st_r.dir;
               st_nxt.rdata[BIT_BUSY] = st_r.active; // abort bit stays 0
            end
            default: st_nxt.rdata = RST_WORD;
         endcase
      end
      if (wrAcc) begin
         unique case (address)
            OFF_PTR_LO: st_nxt.ptr[31:0] = merge(st_r.ptr[31:0], writedata, byteenable);
            OFF_PTR_HI: st_nxt.ptr[63:32] = merge(st_r.ptr[63:32], writedata, byteenable);
            OFF_SIZE_LO: st_nxt.size[31:0] = merge(st_r.size[31:0], writedata, byteenable);
            OFF_SIZE_HI: st_nxt.size[63:32] = merge(st_r.size[63:32], writedata, byteenable);
            OFF_CTRL: begin
               if (byteenable[0]) begin
                  st_nxt.autoStart = writedata[BIT_AUTO];
                  st_nxt.dir = writedata[BIT_DIR];
               end
            end
            default: st_nxt.ptr = st_r.ptr;
         endcase
      end
      // Buffer: pop the head, then push at the first free slot
      if (outFire) begin
         st_nxt.entry[0] = st_r.entry[1];
         st_nxt.fill = st_r.fill - 2'h1;
      end
      if (inFire) begin
         st_nxt.entry[st_nxt.fill[0]] = inXfer;
         st_nxt.fill = st_nxt.fill + 2'h1;
      end
      if (outFire) begin
         st_nxt.rem = st_r.rem - moved;
         if (st_r.rem == moved) begin
            if (st_r.autoStart) begin
               // Pointer is only copied here and at start, so software may rewrite it mid-chain
               st_nxt.rem = st_r.size;
               st_nxt.descAddr = st_r.ptr;
               st_nxt.fetch = 1'b1;
            end else begin
               st_nxt.active = 1'b0;
               st_nxt.fill = 2'h0;
            end
         end
      end
      // Software control overrides the data path; abort wins over start
      if (ctrlWr & writedata[BIT_START] & (st_r.size != RST_WIDE)) begin
         st_nxt.rem = st_r.size;
         st_nxt.descAddr = st_r.ptr;
         st_nxt.fetch = 1'b1;
         st_nxt.active = 1'b1;
      end
      if (ctrlWr & writedata[BIT_ABORT]) begin
         st_nxt.active = 1'b0;
         st_nxt.fetch = 1'b0;
         // No fetch goes out, so the engine copy of the head must not move either
         st_nxt.descAddr = st_r.descAddr;
         st_nxt.fill = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_bus_one_wait: assert property ((read | write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held longer than one cycle");
   a_start_loads: assert property (
      ctrlWr && writedata[BIT_START] && !writedata[BIT_ABORT] && st_r.size != RST_WIDE
      |=> descFetch && dmaActive && st_r.rem == $past(st_r.size))
      else $error("start did not load the working counter");
   a_fetch_addr: assert property (descFetch |-> descAddr == $past(st_r.ptr))
      else $error("fetched descriptor address is not the head pointer");
   a_ptr_held: assert property (!descFetch |-> $stable(descAddr))
      else $error("engine pointer changed without a reload");
   a_rem_dec: assert property (
      outFire && st_r.rem > moved && !ctrlWr |=> st_r.rem == $past(st_r.rem) - $past(moved))
      else $error("working counter not reduced by bytes moved");
   a_zero_reload: assert property (
      outFire && st_r.rem == moved && st_r.autoStart && !ctrlWr
      |=> descFetch && st_r.rem == $past(st_r.size) && dmaActive)
      else $error("no reload at zero with auto-restart");
   a_zero_stop: assert property (
      outFire && st_r.rem == moved && !st_r.autoStart && !ctrlWr |=> !dmaActive && !descFetch)
      else $error("chain continued without auto-restart");
   a_abort_stop: assert property (ctrlWr && writedata[BIT_ABORT] |=> !dmaActive && !outValid)
      else $error("cancel did not stop the engine");
   a_abort_zero: assert property (rdAcc && address == OFF_CTRL |-> !readdata[BIT_ABORT])
      else $error("cancel bit read back as one");
   a_dir_set: assert property (ctrlWr |=> dmaDirection == $past(writedata[BIT_DIR]))
      else $error("direction not taken from control write");
   a_rem_read: assert property (
      read && !waitrequest && address == OFF_REM_HI |-> readdata == $past(st_r.rem[63:32]))
      else $error("remaining high word read wrong");


   // Register bus handshake
   a_wait_first: assert property ($rose(read || write) |-> waitrequest)
      else $error("first cycle of an access was not stalled");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest raised without a request");
   a_ack_pulse: assert property (st_r.ack |=> !st_r.ack)
      else $error("answer strobe stretched over two cycles");
   a_rdata_hold: assert property (!(read && !st_r.ack) |=> $stable(readdata))
      else $error("read data changed outside a read");
   a_unmapped_zero: assert property (rdAcc && address == 5'h1C |-> readdata == RST_WORD)
      else $error("unmapped read did not return zero");

   // Register contents
   a_ptr_lo_wr: assert property (
      wrAcc && address == OFF_PTR_LO && byteenable == 4'hF
      |=> st_r.ptr[31:0] == $past(writedata))
      else $error("head pointer low word not written");
   a_ptr_hi_wr: assert property (
      wrAcc && address == OFF_PTR_HI && byteenable == 4'hF
      |=> st_r.ptr[63:32] == $past(writedata))
      else $error("head pointer high word not written");
   a_size_lo_wr: assert property (
      wrAcc && address == OFF_SIZE_LO && byteenable == 4'hF
      |=> st_r.size[31:0] == $past(writedata))
      else $error("chain total low word not written");
   a_size_hi_wr: assert property (
      wrAcc && address == OFF_SIZE_HI && byteenable == 4'hF
      |=> st_r.size[63:32] == $past(writedata))
      else $error("chain total high word not written");
   a_size_read: assert property (
      rdAcc && address == OFF_SIZE_LO |-> readdata == $past(st_r.size[31:0]))
      else $error("chain total low word read wrong");
   a_rem_lo_read: assert property (
      rdAcc && address == OFF_REM_LO |-> readdata == $past(st_r.rem[31:0]))
      else $error("remaining low word read wrong");
   a_rem_ro: assert property (
      wrAcc && (address == OFF_REM_LO || address == OFF_REM_HI) && !outFire
      |=> $stable(st_r.rem))
      else $error("remaining count took a software write");
   a_auto_set: assert property (ctrlWr |=> st_r.autoStart == $past(writedata[BIT_AUTO]))
      else $error("auto-restart not taken from control write");
   a_dir_hold: assert property (!ctrlWr |=> $stable(dmaDirection))
      else $error("direction changed without a control write");

   // Working counter and chain control
   a_rem_quiet: assert property (!outFire && !ctrlWr |=> $stable(st_r.rem))
      else $error("working counter moved without a transfer");
   a_start_zero: assert property (
      ctrlWr && writedata[BIT_START] && st_r.size == RST_WIDE && !dmaActive |=> !dmaActive)
      else $error("start accepted with an empty chain");
   a_fetch_active: assert property (descFetch |-> dmaActive)
      else $error("descriptor fetch while the engine is idle");
   a_idle_empty: assert property (!dmaActive |-> !outValid)
      else $error("buffer holds words while the engine is idle");

   // Two-entry buffer
   a_fill_max: assert property (st_r.fill <= BUF_DEPTH)
      else $error("buffer fill beyond its depth");
   a_full_refuse: assert property (st_r.fill == BUF_DEPTH |-> !inReady)
      else $error("full buffer still accepting");
   a_idle_refuse: assert property (!dmaActive |-> !inReady)
      else $error("idle engine accepting transfers");
   a_out_hold: assert property (
      outValid && !outReady && !(ctrlWr && writedata[BIT_ABORT])
      |=> outValid && $stable(outXfer))
      else $error("stalled word lost or changed");
   a_pop_order: assert property (outFire && st_r.fill == 2'h2 |=> outXfer == $past(st_r.entry[1]))
      else $error("buffer popped out of order");

   c_auto_reload: cover property (outFire && st_r.rem == moved && st_r.autoStart);
   c_buf_full: cover property (st_r.fill == BUF_DEPTH && !outReady);
   c_abort_busy: cover property (ctrlWr && writedata[BIT_ABORT] && dmaActive);
   c_restart_busy: cover property (ctrlWr && writedata[BIT_START] && dmaActive);
   c_stream_both: cover property (inFire && outFire);
endmodule

/* src/scdr_pkg.sv */
// Constants and carrier types of the chain byte-count and descriptor-pointer reload block.
// Assumes one 40 MHz clock and an Avalon-MM slave with byte addresses.
// Behaviour
// - Descriptor head address is two 32-bit halves
// - Pointer written anytime, taken only at start or reload
// - Chain byte total: two read/write 32-bit halves
// - Start copies chain total into working counter
// - Every transfer decrements the working counter
// - At zero reload count and fetch head
// - Remaining bytes readable as two words
// - Auto-restart bit enables reload at zero
// - Cancel bit stops DMA, reads zero
// - Direction: 0 to host, 1 from host
package scdr_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFF_PTR_LO = 5'h00;
   localparam logic [4:0] OFF_PTR_HI = 5'h04;
   localparam logic [4:0] OFF_SIZE_LO = 5'h08;
   localparam logic [4:0] OFF_SIZE_HI = 5'h0C;
   localparam logic [4:0] OFF_REM_LO = 5'h10;
   localparam logic [4:0] OFF_REM_HI = 5'h14;
   localparam logic [4:0] OFF_CTRL = 5'h18;
   localparam int BIT_AUTO = 0;
   localparam int BIT_ABORT = 1;
   localparam int BIT_DIR = 2;
   localparam int BIT_START = 4;
   localparam int BIT_BUSY = 5;
   localparam logic [63:0] RST_WIDE = 64'h0000_0000_0000_0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef struct packed {
      logic [31:0] data;
      logic [2:0] bytes;
   } scdr_xfer_t;

   typedef struct packed {
      logic [63:0] ptr;
      logic [63:0] size;
      logic [63:0] rem;
      logic [63:0] descAddr;
      logic autoStart;
      logic dir;
      logic active;
      logic fetch;
      logic ack;
      logic [31:0] rdata;
      scdr_xfer_t [1:0] entry;
      logic [1:0] fill;
   } scdr_state_t;
endpackage
